// ### verilog/srl_pkg.sv
// Package for the set/reset latch unit: register map, field positions and reset values.
// Assumes a single 200 MHz clock and an AXI4-Lite register slave in the top module.
// Notes on behaviour
// R1: The latch operates only while control bit 7 is one.
// R2: Control bits 6-4 pick a clock divide from 1/4 up to 1/512.
// R3: Control bit 3 drives the true output onto its pin.
// R4: Control bit 2 drives the inverted output onto its pin.
// R5: Software writes zero to control bits 1 and 0.
// R6: A zero source-select bit makes its source have no effect.
// R7: Source-select bit 6 sets the latch on each divided-clock tick.
// R8: Source-select bit 2 resets the latch on each divided-clock tick.
// R9: Source-select bits 5 and 4 let comparators two and one set the latch.
// R10: Source-select bits 1 and 0 let comparators two and one reset the latch.
// R11: Source-select bit 7 sets the latch while the external input is high.
// R12: Source-select bit 3 resets the latch while the external input is high.
// R13: Software never enables source-select bits 3 and 7 together.
// R14: Simultaneous set and reset leave the latch reset.
// R15: Software can set or reset the latch by command.
// R16: Software makes the output pins outputs itself; here the latch enables each pin from control bit 3 or 2 while bit 7 is one.
// R17: Inverted output is the complement of true output; latch holds otherwise.
// R18: Clock pulses last one cycle, once per divided period, from a prescaler.
`default_nettype none
package srl_pkg;
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_SOURCE = 4'h4;
    localparam logic [3:0] ADDR_COMMAND = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] SOURCE_RESET = 8'h00;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_DIV_LSB = 4;
    localparam int CTL_TRUE_OUT = 3;
    localparam int CTL_INV_OUT = 2;
    localparam int SRC_EXT_SET = 7;
    localparam int SRC_CLK_SET = 6;
    localparam int SRC_CMP2_SET = 5;
    localparam int SRC_CMP1_SET = 4;
    localparam int SRC_EXT_RST = 3;
    localparam int SRC_CLK_RST = 2;
    localparam int SRC_CMP2_RST = 1;
    localparam int SRC_CMP1_RST = 0;
    localparam int CMD_SET = 0;
    localparam int CMD_RESET = 1;
    localparam int PRESCALE_W = 9;
    localparam int DIV_MIN_LOG2 = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } srl_wr_state_t;
endpackage
`default_nettype wire

// ### verilog/srl_prescaler.sv
// Free-running prescaler producing one-cycle ticks at the selected divide.
// Assumes the reset and clock of the latch unit.
`default_nettype none
module srl_prescaler (
    input wire logic ref_clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [2:0] div_sel, // Divide code, 1/4 doubling to 1/512.
    output logic tick // One-cycle pulse per divided period.
);
    logic [srl_pkg::PRESCALE_W-1:0] count_q;
    logic [srl_pkg::PRESCALE_W-1:0] mask;

    // Low bits all ones marks the last cycle of a period of 2^(code+2).
    assign mask = srl_pkg::PRESCALE_W'((1 << (div_sel + srl_pkg::DIV_MIN_LOG2)) - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1; // R18
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= ((count_q & mask) == mask); // R2 R18
        end
    end
endmodule
`default_nettype wire

// ### verilog/srl_core.sv
// Latch state element with reset priority.
// Assumes set and reset requests are synchronous one-cycle or level terms.
`default_nettype none
module srl_core (
    input wire logic ref_clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic set_req, // Combined set request.
    input wire logic rst_req, // Combined reset request.
    output logic state // Latch state.
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= 1'b0;
        end else if (rst_req) begin
            state <= 1'b0; // R14
        end else if (set_req) begin
            state <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### verilog/srl_top.sv
// Set/reset latch unit with AXI4-Lite register slave.
// Assumes comparator and external inputs are synchronous to ref_clk.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`default_nettype none
module srl_top (
    input wire logic ref_clk, // System clock, 200 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic [3:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [3:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic first_comparator, // First comparator output.
    input wire logic second_comparator, // Second comparator output.
    input wire logic latch_external_input, // External latch input pin.
    output logic latch_true_out_pin, // True output pin value.
    output logic latch_true_out_pin_oe, // True output pin claimed by latch.
    output logic latch_inverted_out_pin, // Inverted output pin value.
    output logic latch_inverted_out_pin_oe // Inverted output pin claimed by latch.
);
    // ***********************************
    // Register bus
    // ***********************************
    logic [7:0] control_q;
    logic [7:0] source_q;
    logic [3:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    srl_pkg::srl_wr_state_t wr_state_q;
    logic do_write;
    logic cmd_set_q;
    logic cmd_rst_q;
    logic latch_state;

    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == srl_pkg::ADDR_CONTROL) || (a == srl_pkg::ADDR_SOURCE) ||
                 (a == srl_pkg::ADDR_COMMAND) || (a == srl_pkg::ADDR_STATUS);
    endfunction

    assign do_write = (wr_state_q == srl_pkg::WR_IDLE) && aw_have_q && w_have_q;

    // Address and data are captured independently, in either order.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end else if (wr_state_q == srl_pkg::WR_RESP && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end else if (wr_state_q == srl_pkg::WR_RESP && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_state_q <= srl_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= srl_pkg::RESP_OKAY;
        end else begin
            case (wr_state_q)
                srl_pkg::WR_IDLE: begin
                    if (do_write) begin
                        wr_state_q <= srl_pkg::WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= mapped(aw_addr_q) ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
                    end
                end
                srl_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q <= srl_pkg::WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_q <= srl_pkg::WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Low byte lane only carries register bits; bits 1-0 of control are kept as written.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            control_q <= srl_pkg::CONTROL_RESET;
            source_q <= srl_pkg::SOURCE_RESET;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == srl_pkg::ADDR_CONTROL) begin
                control_q <= w_data_q[7:0];
            end
            if (aw_addr_q == srl_pkg::ADDR_SOURCE) begin
                source_q <= w_data_q[7:0];
            end
        end
    end

    // Commands are one-cycle pulses from a write to the command register.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_set_q <= 1'b0;
            cmd_rst_q <= 1'b0;
        end else begin
            cmd_set_q <= do_write && w_strb_q[0] && (aw_addr_q == srl_pkg::ADDR_COMMAND) &&
                         w_data_q[srl_pkg::CMD_SET]; // R15
            cmd_rst_q <= do_write && w_strb_q[0] && (aw_addr_q == srl_pkg::ADDR_COMMAND) &&
                         w_data_q[srl_pkg::CMD_RESET]; // R15
        end
    end

    // One read at a time; data answer one cycle after the address is taken.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= srl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                srl_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h000000, control_q};
                srl_pkg::ADDR_SOURCE: s_axi_rdata <= {24'h000000, source_q};
                srl_pkg::ADDR_STATUS: s_axi_rdata <= {31'h00000000, latch_state};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ***********************************
    // Latch
    // ***********************************
    logic tick;
    logic active;
    logic set_req;
    logic rst_req;

    assign active = control_q[srl_pkg::CTL_ENABLE]; // R1

    srl_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .rst(rst),
        .div_sel(control_q[srl_pkg::CTL_DIV_LSB +: 3]),
        .tick(tick)
    );

    // Each source counts only when its select bit is one. R6
    assign set_req = active && (cmd_set_q ||
        (source_q[srl_pkg::SRC_CLK_SET] && tick) || // R7
        (source_q[srl_pkg::SRC_CMP2_SET] && second_comparator) || // R9
        (source_q[srl_pkg::SRC_CMP1_SET] && first_comparator) || // R9
        (source_q[srl_pkg::SRC_EXT_SET] && latch_external_input)); // R11
    assign rst_req = active && (cmd_rst_q ||
        (source_q[srl_pkg::SRC_CLK_RST] && tick) || // R8
        (source_q[srl_pkg::SRC_CMP2_RST] && second_comparator) || // R10
        (source_q[srl_pkg::SRC_CMP1_RST] && first_comparator) || // R10
        (source_q[srl_pkg::SRC_EXT_RST] && latch_external_input)); // R12

    srl_core u_core (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_req(set_req),
        .rst_req(rst_req),
        .state(latch_state)
    );

    // ***********************************
    // Output pins
    // ***********************************
    // Pin values lag the latch state by one cycle so each output is a flip-flop.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_true_out_pin <= 1'b0;
            latch_inverted_out_pin <= 1'b1;
            latch_true_out_pin_oe <= 1'b0;
            latch_inverted_out_pin_oe <= 1'b0;
        end else begin
            latch_true_out_pin <= latch_state;
            latch_inverted_out_pin <= ~latch_state; // R17
            latch_true_out_pin_oe <= active && control_q[srl_pkg::CTL_TRUE_OUT]; // R3
            latch_inverted_out_pin_oe <= active && control_q[srl_pkg::CTL_INV_OUT]; // R4
        end
    end

    // ***********************************
    // Checks
    // ***********************************
    property p_reset_wins;
        @(posedge ref_clk) disable iff (rst) rst_req |=> !latch_state;
    endproperty
    a_reset_wins: assert property (p_reset_wins) else $error("reset request did not clear latch"); // R14

    property p_set_works;
        @(posedge ref_clk) disable iff (rst) (set_req && !rst_req) |=> latch_state;
    endproperty
    a_set_works: assert property (p_set_works) else $error("set request did not set latch"); // R11

    property p_hold;
        @(posedge ref_clk) disable iff (rst) (!set_req && !rst_req) |=> $stable(latch_state);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without request"); // R17

    property p_inactive;
        @(posedge ref_clk) disable iff (rst) !active |-> (!set_req && !rst_req);
    endproperty
    a_inactive: assert property (p_inactive) else $error("request while latch disabled"); // R1

    property p_complement;
        @(posedge ref_clk) disable iff (rst) latch_inverted_out_pin == !latch_true_out_pin;
    endproperty
    a_complement: assert property (p_complement) else $error("outputs not complementary"); // R17

    property p_true_pin;
        @(posedge ref_clk) disable iff (rst) 1'b1 |=> latch_true_out_pin == $past(latch_state);
    endproperty
    a_true_pin: assert property (p_true_pin) else $error("true pin does not follow latch"); // R3

    property p_inv_oe;
        @(posedge ref_clk) disable iff (rst) (active && control_q[srl_pkg::CTL_INV_OUT]) |=> latch_inverted_out_pin_oe;
    endproperty
    a_inv_oe: assert property (p_inv_oe) else $error("inverted pin not driven"); // R4

    sequence s_tick_pair;
        tick ##1 !tick;
    endsequence
    property p_tick_one_cycle;
        @(posedge ref_clk) disable iff (rst) tick |-> s_tick_pair;
    endproperty
    a_tick_one_cycle: assert property (p_tick_one_cycle) else $error("tick longer than one cycle"); // R18

    property p_clk_reset;
        @(posedge ref_clk) disable iff (rst) (active && source_q[srl_pkg::SRC_CLK_RST] && tick) |=> !latch_state;
    endproperty
    a_clk_reset: assert property (p_clk_reset) else $error("clock tick did not reset latch"); // R8

    // Ticks sit at least four cycles apart, since every divide keeps the two low count bits.
    sequence s_quiet;
        !tick ##1 !tick ##1 !tick;
    endsequence
    property p_tick_gap;
        @(posedge ref_clk) disable iff (rst) tick |=> s_quiet;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than the smallest divide"); // R2 R18

    property p_clk_set;
        @(posedge ref_clk) disable iff (rst) (active && source_q[srl_pkg::SRC_CLK_SET] && tick && !rst_req) |=> latch_state;
    endproperty
    a_clk_set: assert property (p_clk_set) else $error("clock tick did not set latch"); // R7

    property p_cmp_set;
        @(posedge ref_clk) disable iff (rst)
            (active && source_q[srl_pkg::SRC_CMP1_SET] && first_comparator && !rst_req) |=> latch_state;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("comparator one did not set latch"); // R9

    property p_cmp_reset;
        @(posedge ref_clk) disable iff (rst)
            (active && source_q[srl_pkg::SRC_CMP2_RST] && second_comparator) |=> !latch_state;
    endproperty
    a_cmp_reset: assert property (p_cmp_reset) else $error("comparator two did not reset latch"); // R10

    property p_ext_set;
        @(posedge ref_clk) disable iff (rst)
            (active && source_q[srl_pkg::SRC_EXT_SET] && latch_external_input && !rst_req) |=> latch_state;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("external input did not set latch"); // R11

    property p_ext_reset;
        @(posedge ref_clk) disable iff (rst)
            (active && source_q[srl_pkg::SRC_EXT_RST] && latch_external_input) |=> !latch_state;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("external input did not reset latch"); // R12

    property p_ignored;
        @(posedge ref_clk) disable iff (rst)
            (source_q == 8'h00 && !cmd_set_q && !cmd_rst_q) |=> $stable(latch_state);
    endproperty
    a_ignored: assert property (p_ignored) else $error("latch moved with no source selected"); // R6

    property p_cmd_reset;
        @(posedge ref_clk) disable iff (rst) (active && cmd_rst_q) |=> !latch_state;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset) else $error("reset command did not clear latch"); // R15

    property p_cmd_set;
        @(posedge ref_clk) disable iff (rst) (active && cmd_set_q && !rst_req) |=> latch_state;
    endproperty
    a_cmd_set: assert property (p_cmd_set) else $error("set command did not set latch"); // R15

    property p_disabled_hold;
        @(posedge ref_clk) disable iff (rst) !active |=> $stable(latch_state);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("disabled latch changed"); // R1

    property p_oe_off;
        @(posedge ref_clk) disable iff (rst) !active |=> (!latch_true_out_pin_oe && !latch_inverted_out_pin_oe);
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin claimed while latch disabled"); // R1

    property p_true_oe;
        @(posedge ref_clk) disable iff (rst) (active && control_q[srl_pkg::CTL_TRUE_OUT]) |=> latch_true_out_pin_oe;
    endproperty
    a_true_oe: assert property (p_true_oe) else $error("true pin not driven"); // R3

    property p_inv_pin;
        @(posedge ref_clk) disable iff (rst) 1'b1 |=> latch_inverted_out_pin == !$past(latch_state);
    endproperty
    a_inv_pin: assert property (p_inv_pin) else $error("inverted pin does not follow latch"); // R4 R17

    // A response must stand until the master takes it, or it could be lost.
    property p_bvalid_stands;
        @(posedge ref_clk) disable iff (rst) (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
    endproperty
    a_bvalid_stands: assert property (p_bvalid_stands) else $error("write response dropped early");

    property p_rvalid_stands;
        @(posedge ref_clk) disable iff (rst) (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid;
    endproperty
    a_rvalid_stands: assert property (p_rvalid_stands) else $error("read data dropped early");
endmodule
`default_nettype wire

// ### test/srl_far_model.sv
// Far side of the latch unit: comparators, external input pin and the two pin lines.
// Assumes the bench requests input levels; an unclaimed pin line is pulled low.
`default_nettype none
module srl_far_model (
    input wire logic ref_clk, // System clock.
    input wire logic [2:0] req, // Requested levels: external, comparator two, comparator one.
    output logic first_comparator, // First comparator output.
    output logic second_comparator, // Second comparator output.
    output logic latch_external_input, // External input pin level.
    input wire logic t_val, // True pin value from the latch.
    input wire logic t_oe, // True pin claimed by the latch.
    input wire logic i_val, // Inverted pin value from the latch.
    input wire logic i_oe, // Inverted pin claimed by the latch.
    output logic t_line, // True pin line level.
    output logic i_line // Inverted pin line level.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {latch_external_input, second_comparator, first_comparator} = 3'h0;
    // Sources change on the clock, since the latch samples them as synchronous levels.
    always @(posedge ref_clk) {latch_external_input, second_comparator, first_comparator} <= req;
    // A pin is an output only while claimed; otherwise its pull-down wins.
    assign t_line = t_oe ? t_val : 1'b0;
    assign i_line = i_oe ? i_val : 1'b0;
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the latch unit: AXI4-Lite tasks and directed tests.
// Assumes the far-side model supplies comparator and external input levels.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Signals
    // ****************
    logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, c1, c2, ext, tq, tq_oe, nq, nq_oe, tl, nl;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] req;
    int error_cnt, cmp_count, w, h;
    // The external pin is never both set and reset source.
    logic [7:0] src_t [8] = '{8'h20, 8'h02, 8'h01, 8'h80, 8'h08, 8'h00, 8'h11, 8'h22};
    logic [2:0] stim_t [8] = '{3'h2, 3'h2, 3'h1, 3'h4, 3'h4, 3'h7, 3'h1, 3'h2};
    logic [7:0] pre_v = 8'hF6;
    logic [7:0] exp_v = 8'h29;
    srl_top uut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_comparator(c1),
        .second_comparator(c2), .latch_external_input(ext), .latch_true_out_pin(tq),
        .latch_true_out_pin_oe(tq_oe), .latch_inverted_out_pin(nq), .latch_inverted_out_pin_oe(nq_oe));
    srl_far_model far (.ref_clk(ref_clk), .req(req), .first_comparator(c1), .second_comparator(c2),
        .latch_external_input(ext), .t_val(tq), .t_oe(tq_oe), .i_val(nq), .i_oe(nq_oe),
        .t_line(tl), .i_line(nl));
    // ****************
    // Tasks
    // ****************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        @(posedge ref_clk);
        done = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                `CHK(bresp, er)
                bready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bit done;
        @(posedge ref_clk);
        done = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                `CHK({rresp, rdata}, {srl_pkg::RESP_OKAY, e})
                rready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic drive(input logic [2:0] v);
        req <= v;
        cyc(4);
        req <= 3'h0;
        cyc(3);
    endtask
    task automatic pin_wait(input logic v);
        while (tq !== v) @(posedge ref_clk);
    endtask
    task automatic test_end(input string s);
        $display("Test %s done, mismatches so far %0d", s, error_cnt);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wstrb, wdata, req} = {8'h00, 4'hF, 32'h0, 3'h0};
        cyc(4);
        rst <= 1'b0;
        rd(srl_pkg::ADDR_CONTROL, {24'h0, srl_pkg::CONTROL_RESET});
        rd(srl_pkg::ADDR_SOURCE, {24'h0, srl_pkg::SOURCE_RESET});
        rd(srl_pkg::ADDR_STATUS, 32'h0);
        rd(srl_pkg::ADDR_COMMAND, 32'h0);
        `CHK({tq_oe, nq_oe, tq, nq}, 4'h1)
        wr(4'h2, 32'h8C, srl_pkg::RESP_SLVERR);
        rd(srl_pkg::ADDR_CONTROL, 32'h0);
        test_end("reset");
        // With the latch disabled, comparator one cannot set it; then control is written and read back.
        wr(srl_pkg::ADDR_SOURCE, 32'h10, srl_pkg::RESP_OKAY);
        drive(3'h1);
        rd(srl_pkg::ADDR_STATUS, 32'h0);
        wr(srl_pkg::ADDR_CONTROL, 32'h8C, srl_pkg::RESP_OKAY);
        rd(srl_pkg::ADDR_CONTROL, 32'h8C);
        // A write with the low byte lane off must leave the register alone.
        wstrb <= 4'h0;
        wr(srl_pkg::ADDR_CONTROL, 32'h00, srl_pkg::RESP_OKAY);
        wstrb <= 4'hF;
        rd(srl_pkg::ADDR_CONTROL, 32'h8C);
        drive(3'h1);
        rd(srl_pkg::ADDR_STATUS, 32'h1);
        `CHK({tl, nl, tq_oe, nq_oe}, 4'hB)
        wr(srl_pkg::ADDR_CONTROL, 32'h80, srl_pkg::RESP_OKAY);
        cyc(2);
        `CHK({tl, nl, tq_oe, nq_oe}, 4'h0)
        test_end("enable");
        wr(srl_pkg::ADDR_CONTROL, 32'h8C, srl_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            wr(srl_pkg::ADDR_SOURCE, {24'h0, src_t[i]}, srl_pkg::RESP_OKAY);
            wr(srl_pkg::ADDR_COMMAND, pre_v[i] ? 32'h1 : 32'h2, srl_pkg::RESP_OKAY);
            cyc(2);
            rd(srl_pkg::ADDR_STATUS, {31'h0, pre_v[i]});
            drive(stim_t[i]);
            rd(srl_pkg::ADDR_STATUS, {31'h0, exp_v[i]});
            `CHK(tq ^ nq, 1'b1)
        end
        test_end("sources");
        // Comparator one holds the latch set, so each clock reset tick shows as one low cycle.
        req <= 3'h1;
        wr(srl_pkg::ADDR_SOURCE, 32'h14, srl_pkg::RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            wr(srl_pkg::ADDR_CONTROL, 32'h8C | (c << 4), srl_pkg::RESP_OKAY);
            pin_wait(1'b0);
            pin_wait(1'b1);
            pin_wait(1'b0);
            w = 0;
            h = 0;
            while (tq === 1'b0) begin @(posedge ref_clk); w++; end
            while (tq === 1'b1) begin @(posedge ref_clk); h++; end
            `CHK(w, 1)
            `CHK(w + h, 1 << (c + 2))
        end
        req <= 3'h0;
        wr(srl_pkg::ADDR_SOURCE, 32'h40, srl_pkg::RESP_OKAY);
        wr(srl_pkg::ADDR_CONTROL, 32'hFC, srl_pkg::RESP_OKAY);
        wr(srl_pkg::ADDR_COMMAND, 32'h2, srl_pkg::RESP_OKAY);
        pin_wait(1'b0);
        pin_wait(1'b1);
        rd(srl_pkg::ADDR_STATUS, 32'h1);
        test_end("clock");
        finish_test();
    end
endmodule
`default_nettype wire
